// >>> core/smi_cfg.svh
`ifndef SMI_CFG_SVH
`define SMI_CFG_SVH

// ============================================================
// Serial port
`define SMI_DEV_ADDR        7'h5b
`define SMI_SCL_MAX_KHZ     400
`define SMI_REG_CTRL        8'h00
`define SMI_REG_STAT        8'h01

// ============================================================
// Control byte layout
`define SMI_CTRL_LEVEL_LSB  0
`define SMI_CTRL_LEVEL_MSB  3
`define SMI_CTRL_ACT_BIT    4
`define SMI_CTRL_MSK_BIT    5
`define SMI_LEVEL_RST       4'h7
`define SMI_ACT_RST         1'b1
`define SMI_MSK_RST         1'b0

// ============================================================
// Status byte layout
`define SMI_STAT_UV_BIT     0
`define SMI_STAT_OT_BIT     1

// ============================================================
// Supply monitor, millivolts
`define SMI_TRIP_BASE_MV    12'h8fc
`define SMI_TRIP_STEP_MV    12'h064
`define SMI_HYST_MV         12'h0c8

// ============================================================
// Thermal, degrees C
`define SMI_OT_TRIP_C       8'ha0
`define SMI_OT_HYST_C       8'h14

// ============================================================
// Timing
`define SMI_CLK_PERIOD_NS   5
`define SMI_SS_TIME_NS      400000
`define SMI_SS_STEPS        256

`endif

// >>> core/smi_pkg.sv
package smi_pkg;

  // Gray codes along idle, address, ack, receive, ack, transmit, master ack
  typedef enum logic [2:0] {
    SMI_S_IDLE = 3'h0,
    SMI_S_ADDR = 3'h1,
    SMI_S_AACK = 3'h3,
    SMI_S_RX   = 3'h2,
    SMI_S_RACK = 3'h6,
    SMI_S_TX   = 3'h7,
    SMI_S_MACK = 3'h5
  } smi_i2c_state_t;

endpackage : smi_pkg

// >>> core/smi_regbus_if.sv
`timescale 1ns/1ps
interface smi_regbus_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport port_side (output wr_stb, rd_stb, addr, wdata, input rdata);
  modport reg_side  (input wr_stb, rd_stb, addr, wdata, output rdata);
endinterface : smi_regbus_if

// >>> core/smi_i2c_slave.sv
`timescale 1ns/1ps
`include "smi_cfg.svh"
module smi_i2c_slave import smi_pkg::*; (
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  output logic           sda_out,
  output logic           sda_oe_n_out,
  smi_regbus_if.port_side bus
);
  // ============================================================
  // Synchronisers; 200 MHz gives hundreds of samples per fast-mode bit
  logic [2:0]     scl_q;
  logic [2:0]     sda_q;
  smi_i2c_state_t state;
  logic [7:0]     shift;
  logic [2:0]     cnt;
  logic           done;
  logic           ptr_set;
  logic           mack_ok;
  logic           rw;

  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_ev = scl_q[1] & sda_q[2] & ~sda_q[1];
  wire stop_ev  = scl_q[1] & ~sda_q[2] & sda_q[1];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // ============================================================
  // Byte engine
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state        <= SMI_S_IDLE;
      shift        <= 8'h00;
      cnt          <= 3'h0;
      done         <= 1'b0;
      ptr_set      <= 1'b0;
      mack_ok      <= 1'b0;
      rw           <= 1'b0;
      sda_out      <= 1'b0;
      sda_oe_n_out <= 1'b1;
      bus.wr_stb   <= 1'b0;
      bus.rd_stb   <= 1'b0;
      bus.addr     <= 8'h00;
      bus.wdata    <= 8'h00;
    end else begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      if (start_ev) begin
        state        <= SMI_S_ADDR;
        cnt          <= 3'h0;
        done         <= 1'b0;
        ptr_set      <= 1'b0;
        sda_oe_n_out <= 1'b1;
      end else if (stop_ev) begin
        state        <= SMI_S_IDLE;
        sda_oe_n_out <= 1'b1;
      end else begin
        case (state)
          SMI_S_ADDR, SMI_S_RX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_q[1]};
              cnt   <= cnt + 3'h1;
              done  <= (cnt == 3'h7);
            end else if (scl_fall && done) begin
              done <= 1'b0;
              if (state == SMI_S_ADDR) begin
                if (shift[7:1] == `SMI_DEV_ADDR) begin
                  state        <= SMI_S_AACK;
                  rw           <= shift[0];
                  sda_oe_n_out <= 1'b0;
                end else begin
                  state <= SMI_S_IDLE;
                end
              end else begin
                state        <= SMI_S_RACK;
                sda_oe_n_out <= 1'b0;
                ptr_set      <= 1'b1;
                if (!ptr_set) begin
                  bus.addr <= shift;
                end else begin
                  bus.wdata  <= shift;
                  bus.wr_stb <= 1'b1;
                end
              end
            end
          end
          SMI_S_AACK, SMI_S_RACK: begin
            if (scl_fall) begin
              if (state == SMI_S_AACK && rw) begin
                state        <= SMI_S_TX;
                shift        <= {bus.rdata[6:0], 1'b0};
                sda_oe_n_out <= bus.rdata[7];
                bus.rd_stb   <= 1'b1;
                cnt          <= 3'h0;
              end else begin
                state        <= SMI_S_RX;
                sda_oe_n_out <= 1'b1;
                cnt          <= 3'h0;
              end
            end
          end
          SMI_S_TX: begin
            if (scl_rise) begin
              cnt  <= cnt + 3'h1;
              done <= (cnt == 3'h7);
            end else if (scl_fall) begin
              if (done) begin
                done         <= 1'b0;
                state        <= SMI_S_MACK;
                sda_oe_n_out <= 1'b1;
              end else begin
                sda_oe_n_out <= shift[7];
                shift        <= {shift[6:0], 1'b0};
              end
            end
          end
          SMI_S_MACK: begin
            if (scl_rise) begin
              mack_ok <= ~sda_q[1];
            end else if (scl_fall) begin
              // Further bytes repeat the same register
              if (mack_ok) begin
                state        <= SMI_S_TX;
                shift        <= {bus.rdata[6:0], 1'b0};
                sda_oe_n_out <= bus.rdata[7];
                bus.rd_stb   <= 1'b1;
                cnt          <= 3'h0;
              end else begin
                state <= SMI_S_IDLE;
              end
            end
          end
          default: begin
            sda_oe_n_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // ============================================================
  // Checks
  a_foreign_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == SMI_S_ADDR && scl_fall && done && !start_ev && !stop_ev
      && shift[7:1] != `SMI_DEV_ADDR |=> state == SMI_S_IDLE && sda_oe_n_out)
    else $error("foreign address acknowledged");
  a_ack_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state == SMI_S_AACK || state == SMI_S_RACK) |-> !sda_oe_n_out)
    else $error("ack bit not driven low");
  a_tx_msb: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bus.rd_stb |-> sda_oe_n_out == $past(bus.rdata[7]))
    else $error("read byte not sent msb first");
endmodule : smi_i2c_slave

// >>> core/smi_supervisor.sv
// Overview of operation
// - Slave only, seven-bit address 1011011 plus direction bit.
// - Serial port works up to 400 kHz clock.
// - Writes and reads of configuration registers; further bytes repeat the same register.
// - Bytes go msb first, sampled on serial clock rising edge.
// - Every byte is followed by an acknowledge bit from the receiver; the master ends a read by leaving the last byte unacknowledged.
// - Four-bit trip level: 2.3 V plus 0.1 V per code.
// - Trip level resets to code 0111, 3.0 V.
// - No power-up until supply reaches threshold plus 200 mV.
// - Undervoltage status bit mirrors comparator, 1 when below.
// - Undervoltage stays set until supply exceeds threshold plus 200 mV.
// - Action 1 and unmask 1: falling crossing asserts interrupt low.
// - Interrupt clears after supply recovers and status is read.
// - Action 0: falling crossing disables every regulator at once.
// - Over-temperature disables regulators until cooled by 20 degrees.
// - Enabled converter reference ramps over 400 us soft start.
// - Interrupt is open-drain, low while an enabled source pends.
// - Interrupt sources reset masked, unmasked by register write.
`timescale 1ns/1ps
`include "smi_cfg.svh"
module smi_supervisor import smi_pkg::*; #(
  parameter int unsigned NUM_REGS  = 7,
  parameter int unsigned NUM_BUCKS = 3,
  parameter int unsigned SS_CYCLES =
    `SMI_SS_TIME_NS / `SMI_CLK_PERIOD_NS
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n_out,
  input  wire logic [11:0]             monitored_supply_input_in,
  input  wire logic [7:0]              die_temp_in,
  input  wire logic [NUM_REGS-1:0]     regs_req_in,
  output logic [NUM_REGS-1:0]          regs_en_out,
  output logic [NUM_BUCKS*8-1:0]       ss_ref_out,
  output logic                         undervolt_status_n_out,
  output logic                         irq_out_n_out,
  output logic                         irq_out_n_oe_n_out
);
  localparam int unsigned SS_DIV = SS_CYCLES / `SMI_SS_STEPS;

  smi_regbus_if bus ();

  logic [3:0]  supply_trip_level;
  logic        undervolt_action_select;
  logic        undervolt_irq_unmask;
  logic        uv;
  logic        ot;
  logic        powered;
  logic        irq_pend;
  logic        stat_read;
  logic [NUM_BUCKS-1:0] buck_prev;
  logic [15:0] ss_div_cnt;
  logic        ss_tick;
  logic [11:0] fall_thr;
  logic [11:0] rise_thr;
  logic        uv_fall_ev;
  logic        irq_clr;

  smi_i2c_slave u_port (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe_n_out (sda_oe_n_out),
    .bus          (bus.port_side)
  );

  // ============================================================
  // Register file
  always_comb begin
    case (bus.addr)
      `SMI_REG_CTRL: bus.rdata = {2'h0, undervolt_irq_unmask,
                                  undervolt_action_select, supply_trip_level};
      `SMI_REG_STAT: bus.rdata = {6'h00, ot, uv};
      default:       bus.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      supply_trip_level       <= `SMI_LEVEL_RST;
      undervolt_action_select <= `SMI_ACT_RST;
      undervolt_irq_unmask    <= `SMI_MSK_RST;
    end else if (bus.wr_stb && bus.addr == `SMI_REG_CTRL) begin
      supply_trip_level <=
        bus.wdata[`SMI_CTRL_LEVEL_MSB:`SMI_CTRL_LEVEL_LSB];
      undervolt_action_select <= bus.wdata[`SMI_CTRL_ACT_BIT];
      undervolt_irq_unmask    <= bus.wdata[`SMI_CTRL_MSK_BIT];
    end
  end

  // ============================================================
  // Supply comparator
  // threshold from level code
  assign fall_thr = `SMI_TRIP_BASE_MV
                    + 12'(supply_trip_level) * `SMI_TRIP_STEP_MV;
  assign rise_thr = fall_thr + `SMI_HYST_MV;
  assign uv_fall_ev = !uv && (monitored_supply_input_in < fall_thr);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      uv <= 1'b1;
    end else if (monitored_supply_input_in < fall_thr) begin
      uv <= 1'b1;
    end else if (monitored_supply_input_in > rise_thr) begin
      uv <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      undervolt_status_n_out <= 1'b1;
    end else begin
      undervolt_status_n_out <= uv;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      powered <= 1'b0;
    end else if (uv_fall_ev && !undervolt_action_select) begin
      powered <= 1'b0;
    end else if (!powered && monitored_supply_input_in >= rise_thr) begin
      powered <= 1'b1;
    end
  end

  // ============================================================
  // Thermal
  // trip and cool-down hysteresis
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ot <= 1'b0;
    end else if (die_temp_in > `SMI_OT_TRIP_C) begin
      ot <= 1'b1;
    end else if (die_temp_in <= `SMI_OT_TRIP_C - `SMI_OT_HYST_C) begin
      ot <= 1'b0;
    end
  end

  // ============================================================
  // Interrupt
  assign irq_clr = irq_pend && !uv && stat_read;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stat_read <= 1'b0;
    end else if (bus.rd_stb && bus.addr == `SMI_REG_STAT) begin
      stat_read <= 1'b1;
    end else if (irq_clr || uv_fall_ev) begin
      stat_read <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_pend <= 1'b0;
    end else if (uv_fall_ev && undervolt_action_select
                 && undervolt_irq_unmask && powered) begin
      irq_pend <= 1'b1;
    end else if (irq_clr) begin
      irq_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_out_n_out      <= 1'b0;
      irq_out_n_oe_n_out <= 1'b1;
    end else begin
      irq_out_n_out      <= 1'b0;
      irq_out_n_oe_n_out <= ~(irq_pend && undervolt_irq_unmask);
    end
  end

  // ============================================================
  // Regulator enables
  // global disable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      regs_en_out <= '0;
    end else begin
      regs_en_out <= regs_req_in & {NUM_REGS{powered & ~ot}};
    end
  end

  // ============================================================
  // Soft start; one shared step enable keeps the ramps cheap
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ss_div_cnt <= 16'h0000;
      ss_tick    <= 1'b0;
    end else if (ss_div_cnt >= 16'(SS_DIV - 1)) begin
      ss_div_cnt <= 16'h0000;
      ss_tick    <= 1'b1;
    end else begin
      ss_div_cnt <= ss_div_cnt + 16'h0001;
      ss_tick    <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      buck_prev <= '0;
    end else begin
      buck_prev <= regs_en_out[NUM_BUCKS-1:0];
    end
  end

  for (genvar i = 0; i < NUM_BUCKS; i++) begin : g_ramp
    always_ff @(posedge clk_in) begin
      if (!rst_n_in || !regs_en_out[i]) begin
        ss_ref_out[i*8 +: 8] <= 8'h00;
      end else if (!buck_prev[i]) begin
        ss_ref_out[i*8 +: 8] <= 8'h00;
      end else if (ss_tick && ss_ref_out[i*8 +: 8] != 8'hff) begin
        ss_ref_out[i*8 +: 8] <= ss_ref_out[i*8 +: 8] + 8'h01;
      end
    end

    a_ramp_start: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      regs_en_out[i] && !buck_prev[i] |=> ss_ref_out[i*8 +: 8] == 8'h00)
      else $error("soft start did not begin from zero");
  end

  // ============================================================
  // Checks
  sequence s_uv_fall_alarm;
    uv_fall_ev && undervolt_action_select && undervolt_irq_unmask && powered;
  endsequence

  a_trip_reset: assert property (@(posedge clk_in)
    !rst_n_in |=> supply_trip_level == 4'h7 && !undervolt_irq_unmask)
    else $error("trip level or mask reset wrong");
  a_irq_assert: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    s_uv_fall_alarm ##1 undervolt_irq_unmask |=> !irq_out_n_oe_n_out)
    else $error("interrupt not asserted on crossing");
  a_irq_hold: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    irq_pend && uv |=> irq_pend)
    else $error("interrupt cleared while supply low");
  a_uv_lockout: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    uv_fall_ev && !undervolt_action_select |=> ##1 regs_en_out == '0)
    else $error("regulators left on after lockout");
  a_ot_off: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    ot |=> regs_en_out == '0)
    else $error("regulators on during over-temperature");
  a_powerup_gate: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    !powered |=> regs_en_out == '0)
    else $error("regulators on before power-up threshold");
  a_uv_mirror: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    monitored_supply_input_in < fall_thr |=> ##1 undervolt_status_n_out)
    else $error("status does not show undervoltage");
endmodule : smi_supervisor

// >>> sim/smi_i2c_master_model.sv
`timescale 1ns/1ps
// ============================================================
// Processor-side serial master, 64 ns clock period
module smi_i2c_master_model (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_n_out
);
  // Clock stands high outside frames; data released to pull-up
  initial begin
    scl_out      = 1'b1;
    sda_oe_n_out = 1'b1;
  end

  // one bit, data set while clock low
  task automatic bit_cyc(input logic drv_low, output logic seen);
    #8 sda_oe_n_out = ~drv_low;
    #24 scl_out = 1'b1;
    #16 seen = sda_in;
    #16 scl_out = 1'b0;
  endtask : bit_cyc

  // start, also serves as repeated start
  task automatic start;
    if (!scl_out) begin
      #8 sda_oe_n_out = 1'b1;
      #24 scl_out = 1'b1;
    end
    #16 sda_oe_n_out = 1'b0;
    #16 scl_out = 1'b0;
  endtask : start

  task automatic stop;
    #8 sda_oe_n_out = 1'b0;
    #24 scl_out = 1'b1;
    #16 sda_oe_n_out = 1'b1;
    #16;
  endtask : stop

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(~b[i], s);
    bit_cyc(1'b0, s);
    ack = ~s;
  endtask : wr_byte

  // master acknowledges a received byte when ack is set
  task automatic rd_byte(output logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b0, s);
      b[i] = s;
    end
    bit_cyc(ack, s);
  endtask : rd_byte

  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    a1 = 1'b0;
    a2 = 1'b0;
    start;
    wr_byte({dev, 1'b0}, a0);
    if (a0) begin
      wr_byte(ptr, a1);
      wr_byte(data, a2);
    end
    stop;
    ok = a0 & a1 & a2;
  endtask : reg_wr

  // pointer, repeated start, one byte, no acknowledge
  task automatic reg_rd(input logic [6:0] dev, input logic [7:0] ptr,
                        output logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start;
    wr_byte({dev, 1'b0}, a0);
    wr_byte(ptr, a1);
    start;
    wr_byte({dev, 1'b1}, a2);
    rd_byte(data, 1'b0);
    stop;
    ok = a0 & a1 & a2;
  endtask : reg_rd
endmodule : smi_i2c_master_model

// >>> sim/supply_monitor_i2c_supervisor_tb_top.sv
`timescale 1ns/1ps
`include "smi_cfg.svh"
module supply_monitor_i2c_supervisor_tb_top;
  localparam logic [7:0] CTRL_RST = {2'b00, `SMI_MSK_RST, `SMI_ACT_RST,
                                     `SMI_LEVEL_RST};
  localparam logic [6:0] DEV = `SMI_DEV_ADDR;
  logic        clk, rst_n, scl, sda, m_oe_n, d_sda, d_oe_n, pulled;
  logic        uv, irq_d, irq_oe_n;
  logic [11:0] supply;
  logic [7:0]  temp;
  logic [6:0]  req, regs_en;
  logic [23:0] ss_ref;
  int          errors, n_tests;

  // Wired-AND data line with pull-up
  assign sda = m_oe_n & (d_oe_n | d_sda);

  smi_supervisor #(.SS_CYCLES(2560)) uut (
    .clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(d_sda), .sda_oe_n_out(d_oe_n),
    .monitored_supply_input_in(supply), .die_temp_in(temp),
    .regs_req_in(req), .regs_en_out(regs_en), .ss_ref_out(ss_ref),
    .undervolt_status_n_out(uv), .irq_out_n_out(irq_d),
    .irq_out_n_oe_n_out(irq_oe_n));

  smi_i2c_master_model mst (.sda_in(sda), .scl_out(scl),
                            .sda_oe_n_out(m_oe_n));

  always #2.5 clk = ~clk;
  always @(negedge d_oe_n) pulled = 1'b1;

  // ============================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk_bit(input string what, input logic exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string what, input logic [23:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic wr(input logic [7:0] p, d);
    logic ok;
    mst.reg_wr(DEV, p, d, ok);
    chk_bit("write ack", 1'b1, ok);
  endtask : wr

  task automatic rd_chk(input logic [7:0] p, exp);
    logic [7:0] d;
    logic       ok;
    mst.reg_rd(DEV, p, d, ok);
    chk_bit("read ack", 1'b1, ok);
    chk_val("read data", exp, d);
  endtask : rd_chk

  task automatic set_supply(input logic [11:0] v);
    supply = v;
    step(4);
  endtask : set_supply

  // ============================================================
  // Scenarios
  task automatic t_power;
    logic [7:0] b0, b1;
    logic       a0, a1, a2;
    step(20);
    chk_val("regs before rise", 0, regs_en);
    chk_bit("uv held", 1'b1, uv);
    set_supply(12'd3199);
    chk_val("regs below rise", 0, regs_en);
    set_supply(12'd3200);
    chk_val("regs at rise", 7'h7f, regs_en);
    chk_bit("uv at rise", 1'b1, uv);
    set_supply(12'd3300);
    chk_bit("uv above", 1'b0, uv);
    chk_bit("irq idle", 1'b1, irq_oe_n);
    rd_chk(`SMI_REG_CTRL, CTRL_RST);
    rd_chk(`SMI_REG_STAT, 8'h00);
    rd_chk(8'h05, 8'h00);
    // Master acknowledges the first byte, so the same register comes again
    mst.start;
    mst.wr_byte({DEV, 1'b0}, a0);
    mst.wr_byte(`SMI_REG_CTRL, a1);
    mst.start;
    mst.wr_byte({DEV, 1'b1}, a2);
    mst.rd_byte(b0, 1'b1);
    mst.rd_byte(b1, 1'b0);
    mst.stop;
    chk_bit("burst ack", 1'b1, a0 & a1 & a2);
    chk_val("burst byte 0", CTRL_RST, b0);
    chk_val("burst byte 1", CTRL_RST, b1);
    $display("test power done");
  endtask : t_power

  task automatic t_addr;
    logic ok;
    for (int i = 0; i < 7; i++) begin
      pulled = 1'b0;
      mst.reg_wr(DEV ^ (7'h01 << i), `SMI_REG_CTRL, 8'h00, ok);
      chk_bit("foreign ack", 1'b0, ok);
      chk_bit("foreign pull", 1'b0, pulled);
    end
    // Foreign address, then our own address as a data byte: stay silent
    pulled = 1'b0;
    mst.start;
    mst.wr_byte({DEV ^ 7'h40, 1'b0}, ok);
    mst.wr_byte({DEV, 1'b0}, ok);
    mst.wr_byte(8'h00, ok);
    mst.stop;
    chk_bit("foreign tail pull", 1'b0, pulled);
    wr(`SMI_REG_STAT, 8'hff);
    rd_chk(`SMI_REG_CTRL, CTRL_RST);
    rd_chk(`SMI_REG_STAT, 8'h00);
    $display("test address done");
  endtask : t_addr

  task automatic t_levels;
    logic [11:0] thr;
    for (int l = 0; l < 16; l++) begin
      thr = 12'(`SMI_TRIP_BASE_MV + `SMI_TRIP_STEP_MV * l);
      // Above the highest rising threshold; the supply field is 12 bits
      set_supply(12'd4095);
      wr(`SMI_REG_CTRL, 8'h10 | l[7:0]);
      set_supply(thr);
      chk_bit("uv at thr", 1'b0, uv);
      set_supply(thr - 12'd1);
      chk_bit("uv below thr", 1'b1, uv);
      set_supply(thr + `SMI_HYST_MV);
      chk_bit("uv at hyst", 1'b1, uv);
      set_supply(thr + `SMI_HYST_MV + 12'd1);
      chk_bit("uv above hyst", 1'b0, uv);
      chk_val("regs kept", 7'h7f, regs_en);
    end
    rd_chk(`SMI_REG_CTRL, 8'h1f);
    $display("test levels done");
  endtask : t_levels

  task automatic t_irq;
    wr(`SMI_REG_CTRL, 8'h37);
    set_supply(12'd3300);
    set_supply(12'd2999);
    chk_bit("irq on fall", 1'b0, irq_oe_n);
    chk_bit("irq pin level", 1'b0, irq_d);
    rd_chk(`SMI_REG_STAT, 8'h01);
    set_supply(12'd3200);
    chk_bit("irq before rise", 1'b0, irq_oe_n);
    set_supply(12'd3201);
    chk_bit("irq cleared", 1'b1, irq_oe_n);
    set_supply(12'd2999);
    set_supply(12'd3201);
    chk_bit("irq unread", 1'b0, irq_oe_n);
    rd_chk(`SMI_REG_STAT, 8'h00);
    step(4);
    chk_bit("irq after read", 1'b1, irq_oe_n);
    wr(`SMI_REG_CTRL, CTRL_RST);
    set_supply(12'd2999);
    chk_bit("irq masked", 1'b1, irq_oe_n);
    set_supply(12'd3300);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_lockout;
    wr(`SMI_REG_CTRL, 8'h07);
    set_supply(12'd2999);
    chk_val("regs locked", 0, regs_en);
    set_supply(12'd3199);
    chk_val("regs still off", 0, regs_en);
    set_supply(12'd3200);
    chk_val("regs back", 7'h7f, regs_en);
    wr(`SMI_REG_CTRL, CTRL_RST);
    $display("test lockout done");
  endtask : t_lockout

  task automatic t_thermal;
    temp = `SMI_OT_TRIP_C;
    step(4);
    chk_val("regs at trip", 7'h7f, regs_en);
    temp = `SMI_OT_TRIP_C + 8'h01;
    step(4);
    chk_val("regs hot", 0, regs_en);
    temp = `SMI_OT_TRIP_C - `SMI_OT_HYST_C + 8'h01;
    step(4);
    chk_val("regs cooling", 0, regs_en);
    temp = `SMI_OT_TRIP_C - `SMI_OT_HYST_C;
    step(4);
    chk_val("regs cooled", 7'h7f, regs_en);
    temp = 8'd25;
    $display("test thermal done");
  endtask : t_thermal

  task automatic t_soft;
    req = 7'h7e;
    step(20);
    chk_val("buck0 off", 7'h7e, regs_en);
    req = 7'h7f;
    step(3);
    chk_bit("ramp low", 1'b1, ss_ref[7:0] <= 8'd2);
    step(1280);
    chk_bit("ramp mid", 1'b1, ss_ref[7:0] inside {[120:136]});
    step(1400);
    chk_val("ramp end", 24'hffffff, ss_ref);
    $display("test soft start done");
  endtask : t_soft

  // ============================================================
  // Run control
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Guards against a hung run; counts as a mismatch
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    $display("mismatch run length expected done seen running");
    wrap_up;
  end

  initial begin
    clk    = 1'b0;
    rst_n  = 1'b0;
    supply = 12'd3150;
    temp   = 8'd25;
    req    = 7'h7f;
    pulled = 1'b0;
    errors = 0;
    n_tests = 0;
    step(16);
    rst_n = 1'b1;
    t_power;
    t_addr;
    t_levels;
    t_irq;
    t_lockout;
    t_thermal;
    t_soft;
    wrap_up;
  end
endmodule : supply_monitor_i2c_supervisor_tb_top
